// ---- logic/smc_pkg.sv ----
// Constants, modes, states and carrier types of the sleep mode controller
`default_nettype none
package smc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int BOD_WAKE_US = 60;
    // Least time, so round up to whole cycles
    localparam int BOD_WAKE_CYC = (BOD_WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] STANDBY_WAKE_CYC = 16'h0006;
    localparam logic [15:0] HALT_CYC = 16'h0004;
    localparam logic [15:0] FUSE_BASE_CYC = 16'h0010;
    localparam logic [2:0] BROWNOUT_SLEEP_OFF_WIN_CYC = 3'h4;

    // ----------------------------------------------------------------
    // Control register layout and reset values
    // ----------------------------------------------------------------
    localparam int BROWNOUT_SLEEP_OFF_BIT = 6;
    localparam int BROWNOUT_SLEEP_OFF_EN_BIT = 5;
    localparam logic BROWNOUT_SLEEP_OFF_RESET = 1'b0;
    localparam logic [15:0] CNT_RESET = 16'h0000;

    typedef enum logic [2:0] {
        MODE_IDLE = 3'h0,
        MODE_QUIET = 3'h1,
        MODE_PDOWN = 3'h2,
        MODE_PSAVE = 3'h3,
        MODE_RSV4 = 3'h4,
        MODE_RSV5 = 3'h5,
        MODE_STBY = 3'h6,
        MODE_XSTBY = 3'h7
    } smc_mode_t;

    typedef enum logic [1:0] {
        ST_AWAKE = 2'b00,
        ST_SLEEP = 2'b01,
        ST_START = 2'b11,
        ST_HALT = 2'b10
    } smc_state_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic sleep_arm_bit;
        logic [2:0] sleep_mode_select;
    } smc_ctrl_t;

    typedef struct packed {
        logic ext_interrupt_zero_level;
        logic ext_interrupt_zero_edge;
        logic ext_other;
        logic pin_change;
        logic twi_match;
        logic twi_irq;
        logic timer2;
        logic spm_ee_ready;
        logic adc_done;
        logic wdt_irq;
        logic other_io;
    } smc_wake_t;

    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_osc;
        logic timer_osc;
    } smc_clk_en_t;

    localparam smc_clk_en_t CLK_ALL_ON = 7'h7f;

endpackage : smc_pkg
`default_nettype wire

// ---- logic/smc_sleep_ctrl.sv ----
// Sleep mode controller: clock gating, wake-up sequencing, brown-out sleep control
`default_nettype none

module smc_sleep_ctrl #(
    parameter int BOD_WAKE_CYCLES = smc_pkg::BOD_WAKE_CYC
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire smc_pkg::smc_ctrl_t ctrl_i,
    input wire logic sleep_instr_i,
    input wire smc_pkg::smc_wake_t wake_src_i,
    input wire logic reset_req_i,
    input wire logic timer2_async_i,
    input wire logic adc_enable_i,
    input wire logic [3:0] clock_source_fuses_i,
    input wire logic mcu_ctrl_wr_i,
    input wire logic [7:0] mcu_ctrl_wdata_i,
    output logic brownout_sleep_off_o,
    output smc_pkg::smc_clk_en_t clk_en_o,
    output logic brownout_en_o,
    output logic core_halt_o,
    output logic sleeping_o,
    output logic irq_service_o,
    output logic reset_vector_o,
    output logic adc_start_o
);
    import smc_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        smc_state_t st;
        smc_mode_t mode;
        logic bod_off;
        logic [15:0] cnt;
        logic brownout_sleep_off;
        logic [2:0] win;
        smc_clk_en_t clk_en;
        logic bod_en;
        logic halt;
        logic irq_go;
        logic rst_go;
        logic adc_go;
        logic slp;
    } smc_regs_t;

    smc_regs_t q;
    smc_regs_t d;

    // ----------------------------------------------------------------
    // Per-mode tables
    // ----------------------------------------------------------------
    function automatic smc_wake_t smc_wake_mask(input smc_mode_t m, input logic t2a);
        smc_wake_t w;
        w = '0;
        unique case (m)
            MODE_IDLE: begin
                w = '1;
            end
            MODE_QUIET: begin
                w.ext_interrupt_zero_level = 1'b1;
                w.ext_other = 1'b1;
                w.pin_change = 1'b1;
                w.twi_match = 1'b1;
                w.twi_irq = 1'b1;
                w.timer2 = t2a;
                w.spm_ee_ready = 1'b1;
                w.adc_done = 1'b1;
                w.wdt_irq = 1'b1;
            end
            MODE_PDOWN, MODE_STBY: begin
                w.ext_interrupt_zero_level = 1'b1;
                w.ext_other = 1'b1;
                w.pin_change = 1'b1;
                w.twi_match = 1'b1;
                w.wdt_irq = 1'b1;
            end
            MODE_PSAVE, MODE_XSTBY: begin
                w.ext_interrupt_zero_level = 1'b1;
                w.ext_other = 1'b1;
                w.pin_change = 1'b1;
                w.twi_match = 1'b1;
                w.wdt_irq = 1'b1;
                w.timer2 = t2a;
            end
            MODE_RSV4, MODE_RSV5: begin
                w = '0;
            end
        endcase
        return w;
    endfunction : smc_wake_mask

    function automatic smc_clk_en_t smc_sleep_clocks(input smc_mode_t m, input logic t2a);
        smc_clk_en_t c;
        c = '0;
        unique case (m)
            MODE_IDLE: begin
                c.io = 1'b1;
                c.adc = 1'b1;
                c.main_osc = 1'b1;
                c.asy = t2a;
                c.timer_osc = t2a;
            end
            MODE_QUIET: begin
                c.adc = 1'b1;
                c.main_osc = 1'b1;
                c.asy = t2a;
                c.timer_osc = t2a;
            end
            MODE_PDOWN: begin
                c = '0;
            end
            MODE_PSAVE: begin
                c.asy = t2a;
                c.timer_osc = t2a;
            end
            MODE_STBY: begin
                c.main_osc = 1'b1;
            end
            MODE_XSTBY: begin
                c.main_osc = 1'b1;
                c.asy = t2a;
                c.timer_osc = t2a;
            end
            MODE_RSV4, MODE_RSV5: begin
                c = CLK_ALL_ON;
            end
        endcase
        return c;
    endfunction : smc_sleep_clocks

    // ----------------------------------------------------------------
    // Derived terms
    // ----------------------------------------------------------------
    smc_mode_t sel_mode;
    logic mode_legal;
    logic bod_eligible;
    logic wake_hit;
    logic [15:0] start_cyc;
    logic [15:0] bod_cyc;

    assign sel_mode = smc_mode_t'(ctrl_i.sleep_mode_select);
    // Reserved codes leave the core running rather than guess a mode
    assign mode_legal = (sel_mode != MODE_RSV4) && (sel_mode != MODE_RSV5);
    assign bod_eligible = (sel_mode == MODE_PDOWN) || (sel_mode == MODE_PSAVE)
        || (sel_mode == MODE_STBY) || (sel_mode == MODE_XSTBY);
    assign wake_hit = |(wake_src_i & smc_wake_mask(q.mode, timer2_async_i));
    assign bod_cyc = 16'(BOD_WAKE_CYCLES);

    // Start-up length depends on what was stopped during sleep
    always_comb begin
        unique case (q.mode)
            MODE_PDOWN, MODE_PSAVE: begin
                start_cyc = FUSE_BASE_CYC << clock_source_fuses_i[2:0];
            end
            MODE_STBY, MODE_XSTBY: begin
                start_cyc = STANDBY_WAKE_CYC;
            end
            MODE_IDLE, MODE_QUIET, MODE_RSV4, MODE_RSV5: begin
                start_cyc = 16'h0001;
            end
        endcase
        if (q.bod_off && (start_cyc < bod_cyc)) begin
            start_cyc = bod_cyc;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.irq_go = 1'b0;
        d.rst_go = 1'b0;
        d.adc_go = 1'b0;

        // Timed unlock: enable write opens a short window for the real write
        if (q.win != 3'h0) begin
            d.win = q.win - 3'h1;
        end
        if (mcu_ctrl_wr_i) begin
            if (mcu_ctrl_wdata_i[BROWNOUT_SLEEP_OFF_EN_BIT] && mcu_ctrl_wdata_i[BROWNOUT_SLEEP_OFF_BIT]) begin
                d.win = BROWNOUT_SLEEP_OFF_WIN_CYC;
            end else if (q.win != 3'h0 && !mcu_ctrl_wdata_i[BROWNOUT_SLEEP_OFF_EN_BIT]) begin
                d.brownout_sleep_off = mcu_ctrl_wdata_i[BROWNOUT_SLEEP_OFF_BIT];
                d.win = 3'h0;
            end
        end

        unique case (q.st)
            ST_AWAKE: begin
                // Without the arm bit the instruction does nothing
                if (sleep_instr_i && ctrl_i.sleep_arm_bit && mode_legal) begin
                    d.st = ST_SLEEP;
                    d.mode = sel_mode;
                    d.bod_off = q.brownout_sleep_off && bod_eligible;
                    d.adc_go = adc_enable_i
                        && (sel_mode == MODE_IDLE || sel_mode == MODE_QUIET);
                end
            end
            ST_SLEEP: begin
                if (reset_req_i) begin
                    d.st = ST_AWAKE;
                    d.rst_go = 1'b1;
                    d.bod_off = 1'b0;
                end else if (wake_hit) begin
                    d.st = ST_START;
                    d.cnt = start_cyc;
                end
            end
            ST_START: begin
                if (reset_req_i) begin
                    d.st = ST_AWAKE;
                    d.rst_go = 1'b1;
                    d.bod_off = 1'b0;
                end else if (q.cnt <= 16'h0001) begin
                    d.st = ST_HALT;
                    d.cnt = HALT_CYC;
                    d.bod_off = 1'b0;
                end else begin
                    d.cnt = q.cnt - 16'h0001;
                end
            end
            ST_HALT: begin
                if (reset_req_i) begin
                    d.st = ST_AWAKE;
                    d.rst_go = 1'b1;
                end else if (q.cnt <= 16'h0001) begin
                    d.st = ST_AWAKE;
                    d.irq_go = 1'b1;
                    d.cnt = CNT_RESET;
                end else begin
                    d.cnt = q.cnt - 16'h0001;
                end
            end
        endcase

        // Outputs follow the next state so each one leaves a flip-flop
        unique case (d.st)
            ST_AWAKE: begin
                d.clk_en = CLK_ALL_ON;
                d.halt = 1'b0;
            end
            ST_SLEEP: begin
                d.clk_en = smc_sleep_clocks(d.mode, timer2_async_i);
                d.halt = 1'b1;
            end
            ST_START, ST_HALT: begin
                // Core still held; only CPU and flash stay gated
                d.clk_en = CLK_ALL_ON;
                d.clk_en.cpu = 1'b0;
                d.clk_en.flash = 1'b0;
                d.halt = 1'b1;
            end
        endcase
        d.bod_en = !((d.st == ST_SLEEP) && d.bod_off);
        d.slp = (d.st == ST_SLEEP);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Reset loads every field of q, control state and registered outputs alike
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            q.st <= ST_AWAKE;
            q.mode <= MODE_IDLE;
            q.bod_off <= 1'b0;
            q.cnt <= CNT_RESET;
            q.brownout_sleep_off <= BROWNOUT_SLEEP_OFF_RESET;
            q.win <= 3'h0;
            q.clk_en <= CLK_ALL_ON;
            q.bod_en <= 1'b1;
            q.halt <= 1'b0;
            q.irq_go <= 1'b0;
            q.rst_go <= 1'b0;
            q.adc_go <= 1'b0;
            q.slp <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign brownout_sleep_off_o = q.brownout_sleep_off;
    assign clk_en_o = q.clk_en;
    assign brownout_en_o = q.bod_en;
    assign core_halt_o = q.halt;
    assign sleeping_o = q.slp;
    assign irq_service_o = q.irq_go;
    assign reset_vector_o = q.rst_go;
    assign adc_start_o = q.adc_go;

endmodule : smc_sleep_ctrl
`default_nettype wire

// ---- dv/smc_sleep_chk.sv ----
// Port-level assertions for the sleep mode controller
`default_nettype none
module smc_sleep_chk (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire smc_pkg::smc_ctrl_t ctrl_i,
    input wire logic sleep_instr_i,
    input wire logic reset_req_i,
    input wire logic timer2_async_i,
    input wire logic adc_enable_i,
    input wire logic mcu_ctrl_wr_i,
    input wire logic [7:0] mcu_ctrl_wdata_i,
    input wire logic brownout_sleep_off_o,
    input wire smc_pkg::smc_clk_en_t clk_en_o,
    input wire logic brownout_en_o,
    input wire logic core_halt_o,
    input wire logic sleeping_o,
    input wire logic irq_service_o,
    input wire logic reset_vector_o,
    input wire logic adc_start_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import smc_pkg::*;
    logic awake;
    logic adc_q;
    logic [2:0] mode_q;
    logic [2:0] ent_q;
    assign awake = !sleeping_o && !core_halt_o;
    // Entry mode is not visible at the ports
    always_ff @(posedge clock_i) begin
        mode_q <= ctrl_i.sleep_mode_select;
        adc_q <= adc_enable_i;
        if (sleep_instr_i && awake) begin
            ent_q <= ctrl_i.sleep_mode_select;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_woke;
        $fell(sleeping_o) && !reset_vector_o;
    endsequence
    sequence s_halted;
        (core_halt_o && !irq_service_o)[*5];
    endsequence
    AST_ENTER: assert property (sleep_instr_i && ctrl_i.sleep_arm_bit && awake &&
        ctrl_i.sleep_mode_select[2:1] != 2'b10 |=> sleeping_o && core_halt_o)
        else $error("armed sleep not entered");
    AST_NOOP: assert property (sleep_instr_i && !ctrl_i.sleep_arm_bit && awake
        |=> !sleeping_o && clk_en_o == CLK_ALL_ON) else $error("unarmed sleep acted");
    AST_CPU_OFF: assert property (sleeping_o |-> !clk_en_o.cpu && !clk_en_o.flash)
        else $error("core clock runs in sleep");
    AST_QUIET: assert property ($rose(sleeping_o) && mode_q == 3'h1
        |-> clk_en_o[6:4] == 3'h0 && clk_en_o.adc) else $error("quiet clocks wrong");
    AST_PDOWN: assert property ($rose(sleeping_o) && mode_q == 3'h2 |-> clk_en_o == 7'h00)
        else $error("power-down clocks running");
    AST_ASYNC: assert property (sleeping_o && !timer2_async_i
        |-> !clk_en_o.asy && !clk_en_o.timer_osc) else $error("timer clock not gated");
    AST_HOLD: assert property (s_woke |-> s_halted)
        else $error("core released early");
    AST_SERVE: assert property (irq_service_o
        |-> !core_halt_o && brownout_en_o && clk_en_o == CLK_ALL_ON) else $error("bad resume");
    AST_BOD_ON: assert property ($rose(sleeping_o) && !mode_q[1] |-> brownout_en_o)
        else $error("detector off in shallow mode");
    AST_BOD_WAKE: assert property (!sleeping_o |-> brownout_en_o)
        else $error("detector off while awake");
    AST_BROWNOUT_SLEEP_OFF: assert property (!(mcu_ctrl_wr_i && !mcu_ctrl_wdata_i[5])
        |=> $stable(brownout_sleep_off_o)) else $error("sleep-off bit changed");
    AST_RSTVEC: assert property (reset_req_i && !awake
        |=> reset_vector_o && awake && !irq_service_o) else $error("reset not taken");
    AST_ADC: assert property ($rose(sleeping_o) |-> adc_start_o == (adc_q && !mode_q[1]))
        else $error("conversion start wrong");
    AST_STBY: assert property (s_woke ##0 (ent_q[2:1] == 2'b11 && $past(brownout_en_o))
        |-> ##10 irq_service_o) else $error("standby wake not six cycles");
endmodule : smc_sleep_chk
bind smc_sleep_ctrl smc_sleep_chk smc_sleep_chk_i (.clock_i, .rst_i, .ctrl_i, .sleep_instr_i,
    .reset_req_i, .timer2_async_i, .adc_enable_i, .mcu_ctrl_wr_i, .mcu_ctrl_wdata_i,
    .brownout_sleep_off_o, .clk_en_o, .brownout_en_o, .core_halt_o, .sleeping_o,
    .irq_service_o, .reset_vector_o, .adc_start_o);
`default_nettype wire

// ---- dv/smc_core_model.sv ----
// Core and wake-source model facing the sleep controller
`default_nettype none
module smc_core_model (
    input wire logic clock_i,
    input wire logic irq_service_o,
    input wire logic reset_vector_o,
    output var smc_pkg::smc_ctrl_t ctrl_o,
    output var logic sleep_instr_o,
    output var smc_pkg::smc_wake_t wake_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import smc_pkg::*;
    initial begin
        ctrl_o = '0;
        sleep_instr_o = 1'b0;
        wake_o = '0;
    end
    task automatic sleep(input logic arm, input logic [2:0] mode);
        ctrl_o = {arm, mode};
        sleep_instr_o = 1'b1;
        @(posedge clock_i) #1;
        sleep_instr_o = 1'b0;
    endtask : sleep
    // Answers promptly or a few cycles late
    task automatic wake(input logic [10:0] bits);
        repeat ($urandom_range(3)) @(posedge clock_i) #1;
        wake_o = wake_o | bits;
    endtask : wake
    // Levels held until served, else the wake may be missed
    always @(posedge clock_i) begin
        if (irq_service_o || reset_vector_o) begin
            wake_o <= '0;
        end
    end
endmodule : smc_core_model
`default_nettype wire

// ---- dv/sleep_mode_controller_bench.sv ----
// Self-checking bench for the sleep mode controller
`default_nettype none
module sleep_mode_controller_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import smc_pkg::*;
    localparam int BODC = 20;
    localparam logic [2:0] MT [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic reset_req_i = 1'b0;
    logic t2a = 1'b0;
    logic adc_en = 1'b0;
    logic [3:0] fuse = 4'h0;
    logic wr = 1'b0;
    logic [7:0] wdat = 8'h00;
    smc_ctrl_t ctrl;
    smc_wake_t wk;
    smc_clk_en_t clk_en;
    logic sinstr, brownout_sleep_off, bod_en, halt, slp, irq, rvec, adc_st;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [33:0] exp_q [$];
    smc_sleep_ctrl #(.BOD_WAKE_CYCLES(BODC)) smc_sleep_ctrl_i (.clock_i, .rst_i,
        .ctrl_i(ctrl), .sleep_instr_i(sinstr), .wake_src_i(wk), .reset_req_i,
        .timer2_async_i(t2a), .adc_enable_i(adc_en), .clock_source_fuses_i(fuse),
        .mcu_ctrl_wr_i(wr), .mcu_ctrl_wdata_i(wdat), .brownout_sleep_off_o(brownout_sleep_off),
        .clk_en_o(clk_en), .brownout_en_o(bod_en), .core_halt_o(halt), .sleeping_o(slp),
        .irq_service_o(irq), .reset_vector_o(rvec), .adc_start_o(adc_st));
    smc_core_model smc_core_model_i (.clock_i, .irq_service_o(irq), .reset_vector_o(rvec),
        .ctrl_o(ctrl), .sleep_instr_o(sinstr), .wake_o(wk));
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    task automatic wr_pulse(input logic [7:0] d);
        wr = 1'b1;
        wdat = d;
        @(posedge clock_i) #1;
        wr = 1'b0;
        // Idle edge so a following write never re-raises the strobe at once
        @(posedge clock_i) #1;
    endtask : wr_pulse
    // Enable write held straight into the data write
    task automatic set_brownout_sleep_off(input logic v);
        wr = 1'b1;
        wdat = 8'h60;
        @(posedge clock_i) #1;
        wdat = {1'b0, v, 6'h00};
        @(posedge clock_i) #1;
        wr = 1'b0;
        chk(brownout_sleep_off, v);
    endtask : set_brownout_sleep_off
    function automatic logic [6:0] exp_clk(input logic [2:0] md, input logic a);
        case (md)
            3'h0: return {4'h3, a, 1'b1, a};
            3'h1: return {4'h1, a, 1'b1, a};
            3'h3: return {4'h0, a, 1'b0, a};
            3'h6: return 7'h02;
            3'h7: return {4'h0, a, 1'b1, a};
            default: return 7'h00;
        endcase
    endfunction : exp_clk
    function automatic logic [10:0] wmask(input logic [2:0] md, input logic a);
        case (md)
            3'h0: return 11'h7ff;
            3'h1: return 11'h5ee | {6'h00, a, 4'h0};
            3'h3, 3'h7: return 11'h5c2 | {6'h00, a, 4'h0};
            default: return 11'h5c2;
        endcase
    endfunction : wmask
    function automatic int start_cyc(input logic [2:0] md, input logic [3:0] f, input logic off);
        int s;
        s = md[1] ? (md[2] ? 6 : 16 << f[2:0]) : 1;
        if (off && md[1] && s < BODC) s = BODC;
        return s;
    endfunction : start_cyc
    always @(posedge clock_i) begin
        if (irq || rvec) begin
            chk({rvec, irq, 32'(cyc)}, exp_q.size() ? exp_q.pop_front() : '0);
        end
        cyc <= cyc + 1;
    end
    initial begin
        #100000;
        err_count++;
        results();
    end
    initial begin
        logic [2:0] md;
        logic [10:0] m;
        logic [10:0] ex;
        logic off;
        int b;
        void'($urandom(21979));
        repeat (16) @(posedge clock_i);
        #1 rst_i = 1'b0;
        @(posedge clock_i) #1;
        chk({clk_en, bod_en, halt, slp, brownout_sleep_off}, {CLK_ALL_ON, 4'h8});
        smc_core_model_i.sleep(1'b0, 3'h2);
        chk({slp, clk_en}, {1'b0, CLK_ALL_ON});
        wr_pulse(8'h40);
        chk(brownout_sleep_off, 1'b0);
        wr_pulse(8'h60);
        repeat (3) @(posedge clock_i);
        #1 wr_pulse(8'h40);
        chk(brownout_sleep_off, 1'b0);
        smc_core_model_i.sleep(1'b1, 3'h5);
        chk({slp, halt, clk_en}, {2'b00, CLK_ALL_ON});
        for (int i = 0; i < 24; i++) begin
            md = MT[i % 6];
            t2a = 1'($urandom_range(1));
            adc_en = 1'($urandom_range(1));
            fuse = 4'($urandom_range(15)) & 4'hb;
            off = 1'($urandom_range(1));
            set_brownout_sleep_off(off);
            smc_core_model_i.sleep(1'b1, md);
            ex = {2'h3, exp_clk(md, t2a), !(off && md[1]), adc_en && !md[1]};
            chk({slp, halt, clk_en, bod_en, adc_st}, ex);
            m = wmask(md, t2a);
            b = $urandom_range(10);
            if (!m[b]) begin
                smc_core_model_i.wake(11'(1 << b));
                repeat (3) @(posedge clock_i);
                #1 chk(slp, 1'b1);
                b = 1;
            end
            if (i % 5 == 4) begin
                reset_req_i = 1'b1;
                exp_q.push_back({2'h2, 32'(cyc + 1)});
                @(posedge clock_i) #1;
                reset_req_i = 1'b0;
            end else begin
                smc_core_model_i.wake(11'(1 << b));
                exp_q.push_back({2'h1, 32'(cyc + start_cyc(md, fuse, off) + 5)});
            end
            for (int k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge clock_i) #1;
        end
        // A wake that never answered leaves its note behind
        chk(32'(exp_q.size()), 32'h0);
        results();
    end
endmodule : sleep_mode_controller_bench
`default_nettype wire
